// >>> cpu_ctrl_map.vh
// Register map, field positions, reset values and event codes
// of the processor control register group.
// Assumes a 32-bit AHB-Lite slave with one word per register.
`ifndef CPU_CTRL_MAP_VH
`define CPU_CTRL_MAP_VH

// Byte offsets
`define OFS_STATUS_WORD      8'h00
`define OFS_SHADOW           8'h04
`define OFS_USER_SP          8'h08
`define OFS_SEG_TABLE_BASE   8'h0c
`define OFS_COUNTER_ONE      8'h10
`define OFS_COUNTER_TWO      8'h14
`define OFS_COUNTER_CONFIG   8'h18

// Status word fields
`define SW_ADDR_MODE         16
`define SW_USER_LE           15
`define SW_PRIO_HI           14
`define SW_PRIO_LO           12
`define SW_ENTER_GUARD       11
`define SW_EXEC_LEVEL        10
`define SW_STACK_SEL         9
`define SW_TRACE_BLOCK       8
`define SW_TRACE_INSTR       7
`define SW_OVERFLOW          6
`define SW_CARRY             5
`define SW_FLAG              4
`define SW_WRITE_MASK        32'h0001fff0

// Other fields
`define STB_CACHE_BIT        11
`define STB_KEEP_MASK        32'hfffff800
`define SP_KEEP_MASK         32'hfffffff0
`define CFG_C1_EVENT         22
`define CFG_C1_KERNEL_ONLY   23
`define CFG_C2_KERNEL_ONLY   30
`define CFG_C2_SEL_HI        29
`define CFG_C2_SEL_LO        25
`define CFG_WRITE_MASK       32'hffc00000

// Reset values
`define RST_STATUS_WORD      32'h00000000
`define RST_WORD             32'h00000000

// Second counter event codes
`define C2_SEL_CYCLES        5'h00
`define C2_SEL_INSTR         5'h01
`define C2_SEL_STOP          5'h1f

`endif

// >>> event_counter.v
// Free-running event counter with software load.
// Assumes inc is a one-cycle qualified event in the hclk domain.
`timescale 1ns/100ps
`default_nettype none
module event_counter #(
	parameter WIDTH = 32
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             load,
	input  wire [WIDTH-1:0] load_data,
	input  wire             inc,
	output reg  [WIDTH-1:0] count
);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= {WIDTH{1'b0}};
		end else if (load) begin
			count <= load_data;
		end else if (inc) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // event_counter
`default_nettype wire

// >>> trace_unit.v
// Single-step and basic-block trace sequencer.
// Assumes instr_done pulses once per executed instruction and
// trace_taken pulses when the exception sequencer takes the trace.
`timescale 1ns/100ps
`default_nettype none
module trace_unit (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        trace_instr_en,
	input  wire        trace_block_en,
	input  wire        instr_done,
	input  wire        instr_is_flow,
	input  wire        instr_folded,
	input  wire [31:0] next_pc,
	input  wire        trace_taken,
	output reg         trace_pending,
	output reg  [31:0] trace_pc
);
	wire arm;

	// Folded branches are rejected by this check and never arm
	assign arm = instr_done && !instr_folded && !trace_pending &&
		(trace_instr_en || (trace_block_en && instr_is_flow));

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trace_pending <= 1'b0;
			trace_pc      <= 32'h00000000;
		end else if (arm) begin
			trace_pending <= 1'b1;
			trace_pc      <= next_pc;
		end else if (trace_taken) begin
			trace_pending <= 1'b0;
		end
	end
endmodule // trace_unit
`default_nettype wire

// >>> cpu_status_and_stack_control_regs.v
// Processor control register group: status word, stack shadow,
// user stack pointer, segment table base and two event counters.
// Assumes an AHB-Lite master on hclk and pipeline strobes that are
// one-cycle pulses synchronous to hclk.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_ctrl_map.vh"

// How it works
// - Reset clears whole status word to zero
// - Bit 16 enables translation, else non-cacheable
// - Bit 15 picks user data byte order
// - Accept interrupt below priority or level zero
// - Uneventful frame entry sets guard bit
// - Bit 10 selects kernel or user level
// - Bit 9 selects interrupt or user stack
// - Block trace after call, return or jump
// - Instruction trace; wins over block trace
// - Folded branches alone never trace
// - Overflow and carry kept until next update
// - Flag bit written by flag-setting instructions, bus writes and exception sequences
// - Low four bits reserved, read zero
// - Exception sequences change low half only
// - Shadow follows active stack pointer automatically
// - User stack pointer quad aligned, low zero
// - Table base page aligned, low bits zero
// - Table base write flushes translation buffers
// - Cache bit drives cacheability on table walks
// - Two readable full-width event counters
// - First counter counts cycles or instructions
// - Second counter event select, all-ones stops
module cpu_status_and_stack_control_regs #(
	parameter CNT_WIDTH = 32
) (
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Pipeline and exception sequencer
	input  wire        flag_we,
	input  wire        flag_value,
	input  wire        overflow_we,
	input  wire        overflow_value,
	input  wire        carry_we,
	input  wire        carry_value,
	input  wire        enter_uneventful,
	input  wire        exc_status_we,
	input  wire [15:0] exc_status_low,
	input  wire        user_sp_we,
	input  wire [31:0] user_sp_value,
	input  wire [31:0] interrupt_stack_pointer,
	input  wire        stack_seq_done,
	input  wire        instr_done,
	input  wire        instr_is_flow,
	input  wire        instr_folded,
	input  wire [31:0] next_pc,
	input  wire        trace_taken,
	input  wire [2:0]  interrupt_request_level,
	input  wire [31:0] aux_events,
	input  wire        table_walk_access,
	// State toward translation, trace and interrupt logic
	output wire        translate_enable,
	output wire        non_cacheable_output,
	output wire        user_little_endian,
	output wire        user_level,
	output wire        user_stack_selected,
	output wire [31:0] active_stack_pointer,
	output wire [31:0] stack_pointer_shadow,
	output wire [31:0] user_stack_pointer,
	output wire [31:0] segment_table_base,
	output wire        interrupt_accept,
	output wire        trace_hold,
	output wire        trace_request,
	output wire [31:0] trace_pc,
	output reg         translation_flush
);
	reg  [31:0] program_status_word;
	reg  [31:0] shadow;
	reg  [31:0] user_sp;
	reg  [31:0] seg_base;
	reg  [31:0] counter_config;
	reg  [31:0] prev_active;
	reg         dp_write;
	reg         dp_read;
	reg  [7:0]  dp_addr;
	wire        addr_phase;
	wire        wr_status;
	wire        wr_shadow;
	wire        wr_user_sp;
	wire        wr_seg_base;
	wire        wr_cnt_one;
	wire        wr_cnt_two;
	wire        wr_config;
	wire [31:0] event_counter_one;
	wire [31:0] event_counter_two;
	wire        kernel_ok_one;
	wire        kernel_ok_two;
	wire        inc_one;
	wire [4:0]  c2_sel;
	reg         inc_two;
	reg  [31:0] next_status;
	wire        active_changed;
	wire        trace_pending;
	reg         rd_busy;
	reg  [31:0] read_word;
	wire [2:0]  irq_prio;
	reg         irq_open;

	// One wait state on reads lets hrdata come from a flop; always OKAY
	assign hreadyout  = !rd_busy;
	assign hresp      = 1'b0;
	assign addr_phase = hsel && hready && htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_read  <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (hready) begin
			dp_write <= addr_phase && hwrite;
			dp_read  <= addr_phase && !hwrite;
			dp_addr  <= haddr;
		end
	end

	assign wr_status   = dp_write && (dp_addr == `OFS_STATUS_WORD);
	assign wr_shadow   = dp_write && (dp_addr == `OFS_SHADOW);
	assign wr_user_sp  = dp_write && (dp_addr == `OFS_USER_SP);
	assign wr_seg_base = dp_write && (dp_addr == `OFS_SEG_TABLE_BASE);
	assign wr_cnt_one  = dp_write && (dp_addr == `OFS_COUNTER_ONE);
	assign wr_cnt_two  = dp_write && (dp_addr == `OFS_COUNTER_TWO);
	assign wr_config   = dp_write && (dp_addr == `OFS_COUNTER_CONFIG);

	// Status word next value: bus write, then sequencer, then flags
	always @* begin
		next_status = program_status_word;
		if (wr_status) begin
			next_status = hwdata & `SW_WRITE_MASK;
		end
		if (exc_status_we) begin
			next_status[15:0] = exc_status_low & 16'hfff0;
		end
		if (enter_uneventful) begin
			next_status[`SW_ENTER_GUARD] = 1'b1;
		end
		if (overflow_we) begin
			next_status[`SW_OVERFLOW] = overflow_value;
		end
		if (carry_we) begin
			next_status[`SW_CARRY] = carry_value;
		end
		if (flag_we) begin
			next_status[`SW_FLAG] = flag_value;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			program_status_word <= `RST_STATUS_WORD;
		end else begin
			program_status_word <= next_status;
		end
	end

	// Mode decode
	assign translate_enable    = program_status_word[`SW_ADDR_MODE];
	assign user_little_endian  = program_status_word[`SW_USER_LE];
	assign user_level          = program_status_word[`SW_EXEC_LEVEL];
	assign user_stack_selected = program_status_word[`SW_STACK_SEL];

	// Table walk uses the cache bit, otherwise physical mode forces it
	assign non_cacheable_output = table_walk_access ?
		!seg_base[`STB_CACHE_BIT] :
		!program_status_word[`SW_ADDR_MODE];

	// Level zero always accepted; priority 7 opens every level
	assign irq_prio = program_status_word[`SW_PRIO_HI:`SW_PRIO_LO];

	always @* begin
		irq_open = 1'b0;
		if (interrupt_request_level == 3'h0) begin
			irq_open = 1'b1;
		end else if (irq_prio == 3'h7) begin
			irq_open = 1'b1;
		end else if (interrupt_request_level < irq_prio) begin
			irq_open = 1'b1;
		end
	end
	assign interrupt_accept = irq_open;

	assign active_stack_pointer = user_stack_selected ? user_sp :
		(interrupt_stack_pointer & `SP_KEEP_MASK);

	// User stack pointer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			user_sp <= `RST_WORD;
		end else if (user_sp_we) begin
			user_sp <= user_sp_value & `SP_KEEP_MASK;
		end else if (wr_user_sp) begin
			user_sp <= hwdata & `SP_KEEP_MASK;
		end
	end
	assign user_stack_pointer = user_sp;

	// Shadow follows the active pointer on sequences and changes
	assign active_changed = (active_stack_pointer != prev_active);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_active <= `RST_WORD;
			shadow      <= `RST_WORD;
		end else begin
			prev_active <= active_stack_pointer;
			if (stack_seq_done || active_changed) begin
				shadow <= active_stack_pointer;
			end else if (wr_shadow) begin
				shadow <= hwdata & `SP_KEEP_MASK;
			end
		end
	end
	assign stack_pointer_shadow = shadow;

	// Segment table base; any write flushes translation state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seg_base          <= `RST_WORD;
			translation_flush <= 1'b0;
		end else begin
			translation_flush <= wr_seg_base;
			if (wr_seg_base) begin
				seg_base <= hwdata & `STB_KEEP_MASK;
			end
		end
	end
	assign segment_table_base = seg_base;

	// Counter configuration
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_config <= `RST_WORD;
		end else if (wr_config) begin
			counter_config <= hwdata & `CFG_WRITE_MASK;
		end
	end

	assign kernel_ok_one = !counter_config[`CFG_C1_KERNEL_ONLY] || !user_level;
	assign kernel_ok_two = !counter_config[`CFG_C2_KERNEL_ONLY] || !user_level;
	assign inc_one = kernel_ok_one && (counter_config[`CFG_C1_EVENT] ?
		(instr_done && !instr_folded) : 1'b1);
	assign c2_sel = counter_config[`CFG_C2_SEL_HI:`CFG_C2_SEL_LO];

	always @* begin
		case (c2_sel)
			`C2_SEL_CYCLES: inc_two = 1'b1;
			`C2_SEL_INSTR:  inc_two = instr_done && !instr_folded;
			`C2_SEL_STOP:   inc_two = 1'b0;
			default:        inc_two = aux_events[c2_sel];
		endcase
	end

	event_counter #(
		.WIDTH     (CNT_WIDTH)
	) counter_one (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.load      (wr_cnt_one),
		.load_data (hwdata[CNT_WIDTH-1:0]),
		.inc       (inc_one),
		.count     (event_counter_one)
	);

	event_counter #(
		.WIDTH     (CNT_WIDTH)
	) counter_two (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.load      (wr_cnt_two),
		.load_data (hwdata[CNT_WIDTH-1:0]),
		.inc       (inc_two && kernel_ok_two),
		.count     (event_counter_two)
	);

	trace_unit tracer (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.trace_instr_en (program_status_word[`SW_TRACE_INSTR]),
		.trace_block_en (program_status_word[`SW_TRACE_BLOCK]),
		.instr_done     (instr_done),
		.instr_is_flow  (instr_is_flow),
		.instr_folded   (instr_folded),
		.next_pc        (next_pc),
		.trace_taken    (trace_taken),
		.trace_pending  (trace_pending),
		.trace_pc       (trace_pc)
	);
	assign trace_hold    = trace_pending;
	assign trace_request = trace_pending;

	// Read word picked in the data phase, so a read after a write sees it
	always @* begin
		read_word = 32'h00000000;
		if (dp_read) begin
			case (dp_addr)
				`OFS_STATUS_WORD:    read_word = program_status_word;
				`OFS_SHADOW:         read_word = shadow;
				`OFS_USER_SP:        read_word = user_sp;
				`OFS_SEG_TABLE_BASE: read_word = seg_base;
				`OFS_COUNTER_ONE:    read_word = event_counter_one;
				`OFS_COUNTER_TWO:    read_word = event_counter_two;
				`OFS_COUNTER_CONFIG: read_word = counter_config;
				default:             read_word = 32'h00000000;
			endcase
		end
	end

	// First read data cycle waits and captures; the word stands after it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_busy <= 1'b0;
			hrdata  <= 32'h00000000;
		end else begin
			if (hready) begin
				rd_busy <= addr_phase && !hwrite;
			end else begin
				rd_busy <= 1'b0;
			end
			if (rd_busy) begin
				hrdata <= read_word;
			end
		end
	end
endmodule // cpu_status_and_stack_control_regs
`default_nettype wire

// >>> status_props.sv
// Concurrent checks on the control register group's ports.
// Assumes one hclk domain with hresetn asynchronous and active low.
`timescale 1ns/100ps
`default_nettype none
module status_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        exc_status_we,
	input wire logic [15:0] exc_status_low,
	input wire logic        translate_enable,
	input wire logic        non_cacheable_output,
	input wire logic        user_stack_selected,
	input wire logic        table_walk_access,
	input wire logic [31:0] segment_table_base,
	input wire logic [31:0] user_stack_pointer,
	input wire logic [31:0] active_stack_pointer,
	input wire logic [31:0] interrupt_stack_pointer,
	input wire logic [2:0]  interrupt_request_level,
	input wire logic        interrupt_accept,
	input wire logic        instr_done,
	input wire logic        instr_folded,
	input wire logic        trace_request,
	input wire logic        trace_taken,
	input wire logic        translation_flush
);
	logic       st_wr;
	logic [2:0] prio;
	// Priority field followed from bus writes and sequencer loads
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_wr <= 1'b0;
			prio  <= 3'h0;
		end else begin
			if (hready)
				st_wr <= hsel && htrans[1] && hwrite && haddr == 8'h00;
			if (exc_status_we)
				prio <= exc_status_low[14:12];
			else if (st_wr)
				prio <= hwdata[14:12];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	reset_clear_a: assert property (
		$rose(hresetn) |-> !translate_enable && !user_stack_selected)
		else $error("status not clear after reset");
	phys_nocache_a: assert property (
		!table_walk_access |-> non_cacheable_output == !translate_enable)
		else $error("non-cacheable output wrong for addressing mode");
	walk_cache_a: assert property (
		table_walk_access |-> non_cacheable_output == !segment_table_base[11])
		else $error("table walk cacheability wrong");
	irq_gate_a: assert property (
		interrupt_accept == (interrupt_request_level == 3'h0 ||
		interrupt_request_level < prio || prio == 3'h7))
		else $error("interrupt acceptance wrong");
	usp_align_a: assert property (user_stack_pointer[3:0] == 4'h0)
		else $error("user stack pointer low bits set");
	stb_flush_a: assert property (
		hsel && hready && htrans[1] && hwrite && haddr == 8'h0c |-> ##2 translation_flush)
		else $error("table base write did not flush");
	fold_trace_a: assert property (
		instr_done && instr_folded && !trace_request |=> !trace_request)
		else $error("folded branch traced");
	trace_hold_a: assert property (
		trace_request && !trace_taken |=> trace_request)
		else $error("trace dropped before taken");
	active_sp_a: assert property (active_stack_pointer == (user_stack_selected ?
		user_stack_pointer : interrupt_stack_pointer & 32'hfffffff0))
		else $error("active stack pointer wrong");
endmodule // status_props
`default_nettype wire

// >>> pipe_model.sv
// Far-side model: pipeline, exception sequencer and translation strobes.
// Assumes hclk from the bench; strobes change just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module pipe_model (
	input  wire logic        hclk,
	input  wire logic        trace_request,
	output wire logic        instr_done,
	output wire logic        instr_is_flow,
	output wire logic        instr_folded,
	output wire logic        stack_seq_done,
	output wire logic        user_sp_we,
	output wire logic        exc_status_we,
	output wire logic        enter_uneventful,
	output wire logic        overflow_we,
	output wire logic        carry_we,
	output wire logic        flag_we,
	output logic             overflow_value,
	output logic             carry_value,
	output logic             flag_value,
	output logic [31:0]      next_pc,
	output logic [31:0]      user_sp_value,
	output logic [15:0]      exc_status_low,
	output logic [31:0]      interrupt_stack_pointer,
	output logic [2:0]       interrupt_request_level,
	output logic             table_walk_access,
	output logic             trace_taken
);
	logic [9:0] strobes = 10'h0;
	int         lag = 0;
	int         held = 0;
	assign {instr_done, instr_is_flow, instr_folded, stack_seq_done, user_sp_we,
		exc_status_we, enter_uneventful, overflow_we, carry_we, flag_we} = strobes;
	initial begin
		{overflow_value, carry_value, flag_value, table_walk_access, trace_taken} = 5'h0;
		{next_pc, user_sp_value, exc_status_low} = 80'h0;
		interrupt_stack_pointer = 32'h00001238;
		interrupt_request_level = 3'h0;
	end
	// Takes a pending trace after lag cycles
	always @(posedge hclk) begin
		held <= trace_request && !trace_taken ? held + 1 : 0;
		trace_taken <= trace_request && !trace_taken && held >= lag;
	end
	task automatic step(input logic [9:0] s, input logic [31:0] v);
		@(posedge hclk);
		strobes <= s;
		{next_pc, user_sp_value, exc_status_low} <= {v, v, v[15:0]};
		{overflow_value, carry_value, flag_value} <= v[2:0];
		@(posedge hclk);
		strobes <= 10'h0;
		{next_pc, user_sp_value, exc_status_low} <= ~{v, v, v[15:0]};
		if (|s[2:0])
			repeat (2) @(posedge hclk);
	endtask
endmodule // pipe_model
`default_nettype wire

// >>> test_cpu_status_and_stack_control_regs.sv
// Self-checking bench for the control register group over AHB-Lite.
// Assumes pipe_model as far side and status_props bound to the design.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: %h vs %h", $time, g, e); end end
module test_cpu_status_and_stack_control_regs;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [7:0]  haddr = 8'h00;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] d;
	logic [31:0] aux = 32'h0;
	logic [31:0] mdl [8] = '{default: 32'h0};
	logic [31:0] msk [8] = '{32'h0001fff0, 32'hfffffff0, 32'hfffffff0, 32'hfffff800,
		32'hffffffff, 32'hffffffff, 32'hffc00000, 32'h0};
	logic [4:0]  tc [5] = '{5'h09, 5'h15, 5'h10, 5'h16, 5'h19};
	int          error_cnt = 0, n_tests = 0, i, j, seed = 32'hcd94;
	wire logic   hreadyout, translate_enable, non_cacheable_output, user_little_endian;
	wire logic   user_level, user_stack_selected, interrupt_accept, trace_hold, trace_request;
	wire logic   translation_flush, flag_we, flag_value, overflow_we, overflow_value, carry_we;
	wire logic   carry_value, enter_uneventful, exc_status_we, user_sp_we, stack_seq_done;
	wire logic   instr_done, instr_is_flow, instr_folded, trace_taken, table_walk_access;
	wire logic [2:0]  interrupt_request_level;
	wire logic [15:0] exc_status_low;
	wire logic [31:0] hrdata, active_stack_pointer, stack_pointer_shadow, user_stack_pointer;
	wire logic [31:0] segment_table_base, trace_pc, user_sp_value, interrupt_stack_pointer;
	wire logic [31:0] next_pc;
	cpu_status_and_stack_control_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .flag_we,
		.flag_value, .overflow_we, .overflow_value, .carry_we, .carry_value, .enter_uneventful,
		.exc_status_we, .exc_status_low, .user_sp_we, .user_sp_value, .interrupt_stack_pointer,
		.stack_seq_done, .instr_done, .instr_is_flow, .instr_folded, .next_pc, .trace_taken,
		.interrupt_request_level, .aux_events(aux), .table_walk_access, .translate_enable,
		.non_cacheable_output, .user_little_endian, .user_level, .user_stack_selected,
		.active_stack_pointer, .stack_pointer_shadow, .user_stack_pointer, .segment_table_base,
		.interrupt_accept, .trace_hold, .trace_request, .trace_pc, .translation_flush);
	pipe_model pipe (.hclk, .trace_request, .instr_done, .instr_is_flow, .instr_folded,
		.stack_seq_done, .user_sp_we, .exc_status_we, .enter_uneventful, .overflow_we,
		.carry_we, .flag_we, .overflow_value, .carry_value, .flag_value, .next_pc,
		.user_sp_value, .exc_status_low, .interrupt_stack_pointer, .interrupt_request_level,
		.table_walk_access, .trace_taken);
	always #50 hclk = ~hclk;
	task close_out;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		int k;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		for (k = 0; k < 2; k++) begin
			for (j = 0; j < 50; j++) begin
				@(posedge hclk);
				if (hreadyout === 1'b1)
					break;
			end
			if (j == 50) begin
				error_cnt++;
				close_out;
			end
			if (k == 0) begin
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] r;
		bus(1'b1, a, wd, r);
		mdl[a[4:2]] = wd & msk[a[4:2]];
	endtask
	task automatic rd(input logic [7:0] a);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		`CHK(r, mdl[a[4:2]])
	endtask
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		mdl[1] = 32'h00001230;
		for (i = 0; i < 8; i++)
			if (i != 4 && i != 5) rd(8'(4 * i));
		wr(8'h00, 32'hffffffff);
		rd(8'h00);
		`CHK({translate_enable, user_little_endian, user_level, user_stack_selected}, 4'hf)
		wr(8'h00, 32'h0);
		@(posedge hclk);
		`CHK(non_cacheable_output, 1'b1)
		for (i = 0; i < 6; i++) begin
			d = $random(seed);
			wr(8'h04 + 8'(4 * (i % 3)), d);
			rd(8'h04 + 8'(4 * (i % 3)));
		end
		pipe.table_walk_access <= 1'b1;
		@(posedge hclk);
		`CHK(non_cacheable_output, ~mdl[3][11])
		pipe.table_walk_access <= 1'b0;
		d = $random(seed);
		pipe.step(10'h020, d);
		mdl[2] = d & 32'hfffffff0;
		rd(8'h08);
		wr(8'h00, 32'h200);
		repeat (2) @(posedge hclk);
		mdl[1] = mdl[2];
		rd(8'h04);
		wr(8'h04, mdl[2]);
		wr(8'h00, 32'h0);
		pipe.step(10'h040, 32'h0);
		mdl[1] = 32'h00001230;
		rd(8'h04);
		pipe.step(10'h007, 32'h7);
		mdl[0] = 32'h70;
		rd(8'h00);
		rd(8'h00);
		pipe.step(10'h001, 32'h0);
		mdl[0] = 32'h60;
		rd(8'h00);
		pipe.step(10'h008, 32'h0);
		mdl[0] = 32'h860;
		rd(8'h00);
		rd(8'h00);
		wr(8'h00, 32'h10860);
		d = $random(seed);
		pipe.step(10'h010, d);
		mdl[0] = {mdl[0][31:16], d[15:4], 4'h0};
		rd(8'h00);
		for (i = 0; i < 8; i++) begin
			wr(8'h00, 32'(i) << 12);
			for (j = 0; j < 8; j++) begin
				pipe.interrupt_request_level <= j[2:0];
				@(posedge hclk);
				@(posedge hclk);
				`CHK(interrupt_accept, (j == 0 || j < i || i == 7))
			end
		end
		for (i = 0; i < 5; i++) begin
			pipe.lag = (i % 2) * 3;
			wr(8'h00, {tc[i][4:3], 7'h0});
			d = $random(seed) & 32'hfffffffe;
			pipe.step({1'b1, tc[i][2:1], 7'h0}, d);
			@(posedge hclk);
			`CHK(trace_request, tc[i][0])
			`CHK(trace_hold, tc[i][0])
			if (tc[i][0]) `CHK(trace_pc, d)
			for (j = 0; j < 20 && trace_request; j++)
				@(posedge hclk);
			`CHK(trace_request, 1'b0)
		end
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h3e400000);
		rd(8'h18);
		d = $random(seed);
		wr(8'h14, d);
		rd(8'h14);
		wr(8'h18, 32'h02400000);
		wr(8'h10, 32'h0);
		wr(8'h14, 32'h0);
		for (i = 0; i < 4; i++)
			pipe.step({2'h2, i == 3, 7'h0}, 32'h0);
		mdl[4] = 32'h3;
		mdl[5] = 32'h3;
		rd(8'h10);
		rd(8'h14);
		wr(8'h18, 32'h08000000);
		wr(8'h14, 32'h0);
		aux <= 32'h00000010;
		@(posedge hclk);
		aux <= 32'h0;
		mdl[5] = 32'h1;
		rd(8'h14);
		wr(8'h18, 32'h0);
		for (i = 4; i < 6; i++) begin
			wr(8'(4 * i), 32'hffffffff);
			mdl[i] = 32'h0;
			rd(8'(4 * i));
		end
		close_out;
	end
endmodule // test_cpu_status_and_stack_control_regs
bind cpu_status_and_stack_control_regs status_props chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hready, .translate_enable, .non_cacheable_output, .user_stack_selected,
	.table_walk_access, .segment_table_base, .user_stack_pointer, .active_stack_pointer,
	.interrupt_stack_pointer, .interrupt_request_level, .interrupt_accept, .instr_done,
	.instr_folded, .trace_request, .trace_taken, .translation_flush, .hwdata, .exc_status_we,
	.exc_status_low);
`default_nettype wire
